/* hdl/charger_ctrl_int_status_regs.sv */
// charger control, charger status and sticky event flag registers
`default_nettype none
// What this block does
// [R1] drive select bits 7:6, reset three
// [R2] default-state field bits 5:4, reset zero
// [R3] state 1: detect on aux pin one rise
// [R4] state 2: shorted DCP, low-volt if enabled
// [R5] state 3: auto cycle, 12 s low-volt
// [R6] bit 3 sets supply-switch output polarity
// [R7] bit 2 disables low-volt advertising
// [R8] bit 1 routes aux pin two function in serial mode only
// [R9] bit 0 sets charger-found output polarity
// [R10] status bits 6:4 report charger type
// [R11] status bits 2:0 report advertise state
// [R12] pin one rise sets flag A7
// [R13] pin one fall sets flag A6
// [R14] remote wake sets flag A3
// [R15] disconnect sets flag A2
// [R16] charger found sets flag B5
// [R17] attach sets flag B3
// [R18] overvoltage sets flag B1
// [R19] open-drain interrupt pin pulls low
// [R20] interrupt follows enabled set flags
module charger_ctrl_int_status_regs #(
  parameter int unsigned LV_HOLD_CYCLES = charger_regs_pkg::LV_HOLD_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // register port from the serial management slave
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  // enables held in the interrupt-enable registers
  input  wire logic [7:0] enableA,
  input  wire logic [7:0] enableB,
  // event sources, one-cycle pulses on sys_clk
  input  wire logic       remoteWakeEvt,
  input  wire logic       disconnectEvt,
  input  wire logic       chargerFoundEvt,
  input  wire logic       attachEvt,
  input  wire logic       overvoltageEvt,
  // detector results
  input  wire logic [2:0] detectedChargerType,
  input  wire logic       chargerFoundLevel,
  input  wire logic       supplySwitchReq,
  input  wire logic       serialMode,
  input  wire logic       pinTwoOpenDrain,
  // pins
  input  wire logic       auxPinOneIn,
  output logic            auxPinTwoOut,
  output logic            auxPinTwoOe_n,
  output logic            supplySwitchOut,
  // controls to the analogue charger
  output logic [1:0]      openDrainDriveSelect,
  output logic            startDetection,
  output logic [2:0]      advertMode
);
  import charger_regs_pkg::*;

  logic [7:0] controlQ;
  logic [7:0] flagsAQ;
  logic [7:0] flagsBQ;
  advert_state_t advStateQ;
  logic [31:0] holdCntQ;
  logic pinSync1Q;
  logic pinSync2Q;
  logic pinPrevQ;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire wrControl = regWrite && (regAddr == ADDR_CHARGER_CONTROL);
  wire wrFlagsA  = regWrite && (regAddr == ADDR_EVENT_FLAGS_A);
  wire wrFlagsB  = regWrite && (regAddr == ADDR_EVENT_FLAGS_B);
  wire pinRise   = pinSync2Q && !pinPrevQ;
  wire pinFall   = !pinSync2Q && pinPrevQ;
  wire [1:0] defState  = controlQ[DEFST_HI:DEFST_LO];
  wire       lowVoltOn = !controlQ[LV_DISABLE];
  wire [7:0] statusWord = {1'b0, detectedChargerType, 1'b0, advStateQ};

  // events raised this cycle, placed at their bit positions
  wire [7:0] setA = ({7'h00, pinRise} << A_RISE) | ({7'h00, pinFall} << A_FALL)
                  | ({7'h00, remoteWakeEvt} << A_WAKE)
                  | ({7'h00, disconnectEvt} << A_DISC);
  wire [7:0] setB = ({7'h00, chargerFoundEvt} << B_FOUND)
                  | ({7'h00, attachEvt} << B_ATTACH)
                  | ({7'h00, overvoltageEvt} << B_OVP);
  wire [7:0] clrA = wrFlagsA ? regWdata : 8'h00;
  wire [7:0] clrB = wrFlagsB ? regWdata : 8'h00;
  // set beats clear so an event in the clearing cycle survives
  wire [7:0] flagsAD = ((flagsAQ & ~clrA) | setA) & MASK_FLAGS_A;
  wire [7:0] flagsBD = ((flagsBQ & ~clrB) | setB) & MASK_FLAGS_B;

  wire irqActive = |(flagsAQ & enableA) || |(flagsBQ & enableB);

  wire [7:0] rdMux = (regAddr == ADDR_EVENT_FLAGS_A)   ? flagsAQ  :
                     (regAddr == ADDR_EVENT_FLAGS_B)   ? flagsBQ  :
                     (regAddr == ADDR_CHARGER_CONTROL) ? controlQ :
                     (regAddr == ADDR_CHARGER_STATUS)  ? statusWord : 8'h00;

  wire holdDone = (holdCntQ >= LV_HOLD_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  always_ff @(posedge sys_clk)
  begin
    pinSync1Q <= auxPinOneIn;
    pinSync2Q <= pinSync1Q;
    pinPrevQ  <= pinSync2Q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      // [R1] [R2] drive and default state reset
      controlQ <= RESET_CHARGER_CONTROL;
      flagsAQ  <= RESET_FLAGS;
      flagsBQ  <= RESET_FLAGS;
      regRdata <= 8'h00;
    end
    else
    begin
      if (wrControl)
        controlQ <= regWdata;
      // [R12] [R13] [R14] [R15] sticky A flags
      flagsAQ <= flagsAD;
      // [R16] [R17] [R18] sticky B flags
      flagsBQ <= flagsBD;
      // [R10] [R11] status readback
      if (regRead)
        regRdata <= rdMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // default-state advertising sequence

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      advStateQ <= ADV_NONE;
      holdCntQ  <= 32'h0;
    end
    else
    begin
      case (defState)
        DEF_ADVERTISE:
        begin
          // [R4] shorted DCP choice
          advStateQ <= lowVoltOn ? ADV_LOWVOLT : ADV_BC_DCP;
          holdCntQ  <= 32'h0;
        end
        DEF_AUTOCYCLE:
        begin
          // [R5] [R7] auto cycle with timed low-volt stage
          case (advStateQ)
            ADV_NONE:
            begin
              advStateQ <= ADV_DIVIDER3;
              holdCntQ  <= 32'h0;
            end
            ADV_DIVIDER3:
              advStateQ <= lowVoltOn ? ADV_LOWVOLT : ADV_BC_DCP;
            ADV_LOWVOLT:
            begin
              if (!lowVoltOn || holdDone)
                advStateQ <= ADV_BC_DCP;
              else
                holdCntQ <= holdCntQ + 32'h1;
            end
            default:
              advStateQ <= ADV_BC_DCP;
          endcase
        end
        default:
        begin
          advStateQ <= ADV_NONE;
          holdCntQ  <= 32'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin and control outputs

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      auxPinTwoOut         <= 1'b1;
      auxPinTwoOe_n        <= 1'b1;
      supplySwitchOut      <= 1'b0;
      openDrainDriveSelect <= RESET_CHARGER_CONTROL[DRIVE_HI:DRIVE_LO];
      startDetection       <= 1'b0;
      advertMode           <= ADV_NONE;
    end
    else
    begin
      // [R1] drive strength to pads
      openDrainDriveSelect <= controlQ[DRIVE_HI:DRIVE_LO];
      // [R6] supply switch polarity
      supplySwitchOut <= supplySwitchReq ^ controlQ[SUPPLY_POL];
      // [R3] detection start on rise
      startDetection <= (defState == DEF_DETECT) && pinRise;
      advertMode     <= advStateQ;
      if (serialMode && controlQ[PIN2_FUNC])
      begin
        // [R8] [R9] charger-found output, polarity selectable
        auxPinTwoOut  <= controlQ[FOUND_POL] ? chargerFoundLevel : !chargerFoundLevel;
        auxPinTwoOe_n <= 1'b0;
      end
      else if (pinTwoOpenDrain)
      begin
        // [R19] [R20] open drain pulls low when interrupt active
        auxPinTwoOut  <= 1'b0;
        auxPinTwoOe_n <= !irqActive;
      end
      else
      begin
        // [R20] push-pull active-low interrupt
        auxPinTwoOut  <= !irqActive;
        auxPinTwoOe_n <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_rise_flag;
    @(posedge sys_clk) disable iff (rst)
    pinRise |=> flagsAQ[A_RISE];
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rise flag not set"); // [R12]

  property p_fall_flag;
    @(posedge sys_clk) disable iff (rst)
    pinFall |=> flagsAQ[A_FALL];
  endproperty
  a_fall_flag: assert property (p_fall_flag) else $error("fall flag not set"); // [R13]

  property p_wake_flag;
    @(posedge sys_clk) disable iff (rst)
    remoteWakeEvt |=> flagsAQ[A_WAKE];
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("wake flag not set"); // [R14]

  property p_disc_flag;
    @(posedge sys_clk) disable iff (rst)
    disconnectEvt |=> flagsAQ[A_DISC];
  endproperty
  a_disc_flag: assert property (p_disc_flag) else $error("disconnect flag not set"); // [R15]

  property p_found_hold;
    @(posedge sys_clk) disable iff (rst)
    flagsBQ[B_FOUND] && !(wrFlagsB && regWdata[B_FOUND]) |=> flagsBQ[B_FOUND];
  endproperty
  a_found_hold: assert property (p_found_hold) else $error("found flag lost"); // [R16]

  property p_attach_flag;
    @(posedge sys_clk) disable iff (rst)
    attachEvt |=> flagsBQ[B_ATTACH];
  endproperty
  a_attach_flag: assert property (p_attach_flag) else $error("attach flag not set"); // [R17]

  property p_ovp_clear;
    @(posedge sys_clk) disable iff (rst)
    wrFlagsB && regWdata[B_OVP] && !overvoltageEvt |=> !flagsBQ[B_OVP];
  endproperty
  a_ovp_clear: assert property (p_ovp_clear) else $error("overvoltage flag not cleared"); // [R18]

  property p_detect_start;
    @(posedge sys_clk) disable iff (rst)
    (defState == DEF_DETECT) && pinRise |=> startDetection;
  endproperty
  a_detect_start: assert property (p_detect_start) else $error("detection not started"); // [R3]

  property p_advert_short;
    @(posedge sys_clk) disable iff (rst)
    (defState == DEF_ADVERTISE) && !lowVoltOn |=> advStateQ == ADV_BC_DCP;
  endproperty
  a_advert_short: assert property (p_advert_short) else $error("wrong advert"); // [R4]

  property p_irq_pin;
    @(posedge sys_clk) disable iff (rst)
    irqActive && pinTwoOpenDrain && !(serialMode && controlQ[PIN2_FUNC])
      |=> !auxPinTwoOe_n && !auxPinTwoOut;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin not low"); // [R19]

  // sampled rst keeps the release edge out, when outputs still hold reset values
  property p_drive_copy;
    @(posedge sys_clk) disable iff (rst)
    !rst |=> openDrainDriveSelect == $past(controlQ[DRIVE_HI:DRIVE_LO]);
  endproperty
  a_drive_copy: assert property (p_drive_copy) else $error("drive select not copied"); // [R1]

  property p_supply_pol;
    @(posedge sys_clk) disable iff (rst)
    !rst |=> supplySwitchOut == ($past(supplySwitchReq) ^ $past(controlQ[SUPPLY_POL]));
  endproperty
  a_supply_pol: assert property (p_supply_pol) else $error("supply switch polarity"); // [R6]

  property p_found_pin;
    @(posedge sys_clk) disable iff (rst)
    !rst && serialMode && controlQ[PIN2_FUNC]
      |=> !auxPinTwoOe_n
      && (auxPinTwoOut == ($past(chargerFoundLevel) ~^ $past(controlQ[FOUND_POL])));
  endproperty
  a_found_pin: assert property (p_found_pin) else $error("charger found pin wrong"); // [R9]

  property p_pushpull_irq;
    @(posedge sys_clk) disable iff (rst)
    !rst && !pinTwoOpenDrain && !(serialMode && controlQ[PIN2_FUNC])
      |=> !auxPinTwoOe_n && (auxPinTwoOut == !$past(irqActive));
  endproperty
  a_pushpull_irq: assert property (p_pushpull_irq) else $error("push-pull interrupt wrong"); // [R20]

  property p_od_release;
    @(posedge sys_clk) disable iff (rst)
    !rst && !irqActive && pinTwoOpenDrain && !(serialMode && controlQ[PIN2_FUNC])
      |=> auxPinTwoOe_n;
  endproperty
  a_od_release: assert property (p_od_release) else $error("interrupt pin not released"); // [R20]

  property p_rise_clear;
    @(posedge sys_clk) disable iff (rst)
    wrFlagsA && regWdata[A_RISE] && !pinRise |=> !flagsAQ[A_RISE];
  endproperty
  a_rise_clear: assert property (p_rise_clear) else $error("rise flag not cleared"); // [R12]

  property p_auto_skip_lv;
    @(posedge sys_clk) disable iff (rst)
    (defState == DEF_AUTOCYCLE) && !lowVoltOn |=> advStateQ != ADV_LOWVOLT;
  endproperty
  a_auto_skip_lv: assert property (p_auto_skip_lv) else $error("low-volt stage not skipped"); // [R7]

endmodule
`default_nettype wire

/* hdl/charger_regs_pkg.sv */
// constants for the charger control and event flag register bank
`default_nettype none
package charger_regs_pkg;
  localparam logic [7:0] ADDR_EVENT_FLAGS_A    = 8'ha3;
  localparam logic [7:0] ADDR_EVENT_FLAGS_B    = 8'ha4;
  localparam logic [7:0] ADDR_CHARGER_CONTROL  = 8'hb6;
  localparam logic [7:0] ADDR_CHARGER_STATUS   = 8'hb7;
  localparam logic [7:0] RESET_CHARGER_CONTROL = 8'hc0;
  localparam logic [7:0] RESET_FLAGS           = 8'h00;
  // charger_control fields
  localparam int DRIVE_HI    = 7;
  localparam int DRIVE_LO    = 6;
  localparam int DEFST_HI    = 5;
  localparam int DEFST_LO    = 4;
  localparam int SUPPLY_POL  = 3;
  localparam int LV_DISABLE  = 2;
  localparam int PIN2_FUNC   = 1;
  localparam int FOUND_POL   = 0;
  // charger_status fields
  localparam int TYPE_HI     = 6;
  localparam int TYPE_LO     = 4;
  localparam int ADV_HI      = 2;
  localparam int ADV_LO      = 0;
  // event flag bit positions
  localparam int A_RISE      = 7;
  localparam int A_FALL      = 6;
  localparam int A_WAKE      = 3;
  localparam int A_DISC      = 2;
  localparam int B_FOUND     = 5;
  localparam int B_ATTACH    = 3;
  localparam int B_OVP       = 1;
  localparam logic [7:0] MASK_FLAGS_A = 8'hcc;
  localparam logic [7:0] MASK_FLAGS_B = 8'h2a;
  // low-voltage advertising hold
  localparam int unsigned CLK_HZ       = 25000000;
  localparam int unsigned LV_HOLD_S    = 12;
  localparam int unsigned LV_HOLD_CYC  = LV_HOLD_S * CLK_HZ;
  typedef enum logic [1:0] {
    DEF_IDLE      = 2'b00,
    DEF_DETECT    = 2'b01,
    DEF_ADVERTISE = 2'b10,
    DEF_AUTOCYCLE = 2'b11
  } default_state_t;
  typedef enum logic [2:0] {
    ADV_NONE     = 3'b000,
    ADV_DIVIDER3 = 3'b101,
    ADV_LOWVOLT  = 3'b110,
    ADV_BC_DCP   = 3'b111
  } advert_state_t;
endpackage
`default_nettype wire

/* sim/reg_host_model.sv */
// host model that issues single-byte register port accesses
`default_nettype none
module reg_host_model (
  // clock
  input  wire logic       sys_clk,
  // register port
  output var  logic       regWrite,
  output var  logic       regRead,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWdata,
  input  wire logic [7:0] regRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 8'h00;
    regWdata = 8'h00;
  end
  // idle lines flip so a stale address or data byte never looks held
  task automatic idle_bus();
    regWrite <= 1'b0;
    regRead  <= 1'b0;
    regAddr  <= ~regAddr;
    regWdata <= ~regWdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge sys_clk);
    idle_bus();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    idle_bus();
    @(posedge sys_clk);
    d = regRdata;
  endtask
endmodule
`default_nettype wire

/* sim/test_charger_ctrl_int_status_regs.sv */
// self-checking bench for the charger control and event flag bank
`default_nettype none
module test_charger_ctrl_int_status_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import charger_regs_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       regWrite, regRead, pinTwo, pinTwoOe_n, supOut, startDet;
  logic [7:0] regAddr, regWdata, regRdata, rv;
  logic [7:0] enableA = 8'h00;
  logic [7:0] enableB = 8'h2a;
  logic [4:0] evts = 5'h00;
  logic       foundLvl = 1'b0, supReq = 1'b0, serMode = 1'b1, odMode = 1'b0, pinOne = 1'b0;
  logic [2:0] chType = 3'h5;
  logic [2:0] advMode;
  logic [1:0] drvSel;
  int         errors = 0, checks = 0, starts = 0;

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (startDet === 1'b1) starts++;

  reg_host_model host (.sys_clk(sys_clk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));

  charger_ctrl_int_status_regs #(.LV_HOLD_CYCLES(20)) uut (.sys_clk(sys_clk), .rst(rst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .enableA(enableA), .enableB(enableB), .remoteWakeEvt(evts[4]),
    .disconnectEvt(evts[3]), .chargerFoundEvt(evts[2]), .attachEvt(evts[1]),
    .overvoltageEvt(evts[0]), .detectedChargerType(chType), .chargerFoundLevel(foundLvl),
    .supplySwitchReq(supReq), .serialMode(serMode), .pinTwoOpenDrain(odMode),
    .auxPinOneIn(pinOne), .auxPinTwoOut(pinTwo), .auxPinTwoOe_n(pinTwoOe_n),
    .supplySwitchOut(supOut), .openDrainDriveSelect(drvSel), .startDetection(startDet),
    .advertMode(advMode));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string what);
    host.rd(a, rv);
    chk(what, rv, exp);
  endtask
  task automatic pulse(input logic [4:0] v);
    @(posedge sys_clk);
    evts <= v;
    @(posedge sys_clk);
    evts <= 5'h00;
  endtask
  task automatic close_out();
    if (errors == 0 && checks > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rc(ADDR_CHARGER_CONTROL, 8'hc0, "control reset");
    chk("drive select", {6'h00, drvSel}, 8'h03);
    rc(ADDR_EVENT_FLAGS_A, 8'h00, "flags a reset");
    rc(ADDR_EVENT_FLAGS_B, 8'h00, "flags b reset");
    rc(ADDR_CHARGER_STATUS, 8'h50, "status reset");
    rc(8'h10, 8'h00, "unmapped read");
  endtask
  task automatic t_control();
    foundLvl <= 1'b1;
    host.wr(ADDR_CHARGER_CONTROL, 8'h0b);
    repeat (2) @(posedge sys_clk);
    rc(ADDR_CHARGER_CONTROL, 8'h0b, "control readback");
    chk("drive select", {6'h00, drvSel}, 8'h00);
    chk("supply switch", {7'h00, supOut}, 8'h01);
    chk("pin two level", {7'h00, pinTwo}, 8'h01);
    chk("pin two enable", {7'h00, pinTwoOe_n}, 8'h00);
    supReq <= 1'b1;
    host.wr(ADDR_CHARGER_CONTROL, 8'h0a);
    repeat (2) @(posedge sys_clk);
    chk("pin two low pol", {7'h00, pinTwo}, 8'h00);
    chk("supply switch low", {7'h00, supOut}, 8'h00);
    host.wr(ADDR_CHARGER_STATUS, 8'hff);
    rc(ADDR_CHARGER_STATUS, 8'h50, "status read only");
  endtask
  task automatic t_events();
    pulse(5'h1f);
    rc(ADDR_EVENT_FLAGS_A, 8'h0c, "flags a set");
    rc(ADDR_EVENT_FLAGS_B, 8'h2a, "flags b set");
    host.wr(ADDR_EVENT_FLAGS_A, 8'h08);
    rc(ADDR_EVENT_FLAGS_A, 8'h04, "flags a one clear");
    host.wr(ADDR_EVENT_FLAGS_A, 8'hff);
    host.wr(ADDR_EVENT_FLAGS_B, 8'hff);
    rc(ADDR_EVENT_FLAGS_A, 8'h00, "flags a clear");
    rc(ADDR_EVENT_FLAGS_B, 8'h00, "flags b clear");
  endtask
  task automatic t_interrupt();
    odMode <= 1'b1;
    enableA <= 8'h08;
    host.wr(ADDR_CHARGER_CONTROL, 8'h00);
    pulse(5'h10);
    repeat (3) @(posedge sys_clk);
    chk("int pin level", {7'h00, pinTwo}, 8'h00);
    chk("int pin asserted", {7'h00, pinTwoOe_n}, 8'h00);
    host.wr(ADDR_EVENT_FLAGS_A, 8'h08);
    repeat (3) @(posedge sys_clk);
    chk("int pin released", {7'h00, pinTwoOe_n}, 8'h01);
    // outside serial mode the function bit must not route the found level
    odMode <= 1'b0;
    serMode <= 1'b0;
    host.wr(ADDR_CHARGER_CONTROL, 8'h03);
    pulse(5'h10);
    repeat (3) @(posedge sys_clk);
    chk("push-pull int low", {7'h00, pinTwo}, 8'h00);
    chk("push-pull drives", {7'h00, pinTwoOe_n}, 8'h00);
    host.wr(ADDR_EVENT_FLAGS_A, 8'h08);
    repeat (3) @(posedge sys_clk);
    chk("push-pull int high", {7'h00, pinTwo}, 8'h01);
    serMode <= 1'b1;
  endtask
  task automatic t_pin_one();
    host.wr(ADDR_CHARGER_CONTROL, 8'h10);
    starts = 0;
    pinOne <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rc(ADDR_EVENT_FLAGS_A, 8'h80, "rise flag");
    chk("detect starts", 8'(starts), 8'h01);
    pinOne <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rc(ADDR_EVENT_FLAGS_A, 8'hc0, "fall flag");
  endtask
  task automatic t_advert();
    host.wr(ADDR_CHARGER_CONTROL, 8'h30);
    repeat (5) @(posedge sys_clk);
    chk("auto low volt", {5'h00, advMode}, 8'h06);
    repeat (30) @(posedge sys_clk);
    chk("auto final", {5'h00, advMode}, 8'h07);
    rc(ADDR_CHARGER_STATUS, 8'h57, "status advert");
    host.wr(ADDR_CHARGER_CONTROL, 8'h20);
    repeat (3) @(posedge sys_clk);
    chk("advert low volt", {5'h00, advMode}, 8'h06);
    host.wr(ADDR_CHARGER_CONTROL, 8'h24);
    repeat (3) @(posedge sys_clk);
    chk("advert lv off", {5'h00, advMode}, 8'h07);
    host.wr(ADDR_CHARGER_CONTROL, 8'h04);
    host.wr(ADDR_CHARGER_CONTROL, 8'h34);
    repeat (4) @(posedge sys_clk);
    chk("auto lv off", {5'h00, advMode}, 8'h07);
    chType <= 3'h2;
    rc(ADDR_CHARGER_STATUS, 8'h27, "status type");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_control();
    t_events();
    t_interrupt();
    t_pin_one();
    t_advert();
    close_out();
  end
  // whole run is under two hundred cycles
  initial
  begin
    #(40 * 3000);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
